// >>> src/fdcs_core.sv
// Fieldbus drive command interpreter and status word builder.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Reference is 16 bits, 0x4000 means 100%
// - Negative references use two's complement
// - Actual value uses the reference scaling
// - Bit 00 low gives ramp stop
// - Bit 01 low gives coasting stop
// - Bit 02 low gives quick stop
// - Bit 03 low coasts, high permits start
// - Bit 04 low quick stops, high permits
// - Bit 05 low freezes output frequency
// - Bit 06 low ramp stops, high permits
// - Fault reset only on bit 07 rise
// - Jog bits need 04 low, 00-03 high
// - Bit 10 low ignores whole command
// - Bit 11 reduces reference by trim
// - Bit 12 raises; reduce has priority
// - Bits 13/14 pick one of four setups
// - Running setup change needs linked setups
// - Bit 15 reverses unless source digital
// - Status 00 ready when control ready, unless stop or trip
// - Status 01 also needs power supply
// - Status 02 enable when 00-02 high and no trip
// - Status bits 03, 07-15 report drive flags
// - Status 04/05 mirror command 01/02
// - Status 06 start-not-possible set and clear
module fdcs_core (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        TEL_VALID,
   input  wire logic [15:0] CMD_WORD,
   input  wire logic [15:0] SPEED_REF,
   input  wire logic [15:0] ACT_FREQ,
   input  wire logic        TRIP,
   input  wire logic        CTRL_READY,
   input  wire logic        POWER_OK,
   input  wire logic        WARNING,
   input  wire logic        AT_REF,
   input  wire logic        BUS_CTRL,
   input  wire logic        FREQ_OK,
   input  wire logic        IN_OPERATION,
   input  wire logic        AUTO_RESTART,
   input  wire logic        VOLT_EXC,
   input  wire logic        TORQUE_EXC,
   input  wire logic        TIMER_EXC,
   input  wire logic [14:0] TRIM_VALUE,
   input  wire logic [15:0] JOG1_SPEED,
   input  wire logic [15:0] JOG2_SPEED,
   input  wire logic        MULTI_SETUP,
   input  wire logic [3:0]  SETUP_LINK,
   input  wire logic [1:0]  REV_SRC,
   input  wire logic        RELAY_FN,
   output logic      [15:0] STATE_WORD,
   output logic      [15:0] ACTUAL_VALUE,
   output logic             REPLY_VALID,
   output logic      [15:0] SPEED_CMD,
   output logic      [1:0]  STOP_MODE,
   output logic             HOLD_FREQ,
   output logic             FAULT_RESET,
   output logic             REVERSE,
   output logic      [1:0]  ACTIVE_SETUP,
   output logic             RELAY_OUT
);
   logic                     rst_s1_q;
   logic                     rst_n;
   logic [15:0]              cmd_q, cmd_d;
   logic [15:0]              raw_q, raw_d;
   logic signed [15:0]       ref_q, ref_d;
   logic                     tel_q, tel_d;
   logic [15:0]              stw_q, stw_d;
   logic [15:0]              act_q, act_d;
   logic                     rep_q, rep_d;
   logic signed [15:0]       spd_q, spd_d;
   fdcs_pkg::fdcs_stop_t     stop_q, stop_d;
   logic                     hold_q, hold_d;
   logic                     fres_q, fres_d;
   logic                     b7_q, b7_d;
   logic                     rev_q, rev_d;
   logic [1:0]               setup_q, setup_d;
   logic                     relay_q, relay_d;
   logic                     nost_q, nost_d;
   logic signed [15:0]       base;
   logic                     ok3;

   fdcs_cmd_if c ();

   assign c.word = cmd_q;

   fdcs_decode u_dec (
      .c       (c),
      .rev_src (REV_SRC)
   );

   // Reset is released through two flops so all state leaves it together.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Telegram intake stage.
   always_comb begin
      cmd_d = cmd_q;
      raw_d = raw_q;
      ref_d = ref_q;
      tel_d = TEL_VALID;
      if (TEL_VALID) begin
         raw_d = CMD_WORD;
         ref_d = $signed(SPEED_REF);
         if (CMD_WORD[fdcs_pkg::C_VALID]) begin
            cmd_d = CMD_WORD;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= fdcs_pkg::CMD_RST;
         raw_q <= fdcs_pkg::CMD_RST;
         ref_q <= fdcs_pkg::REF_RST;
         tel_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         raw_q <= raw_d;
         ref_q <= ref_d;
         tel_q <= tel_d;
      end
   end

   // Reply stage: one cycle after intake, outputs are refreshed; SPEED_CMD keeps its value while bit 05 is low.
   always_comb begin
      ok3 = &cmd_q[2:0] & ~TRIP;
      stw_d = stw_q;
      act_d = act_q;
      spd_d = spd_q;
      stop_d = stop_q;
      hold_d = hold_q;
      b7_d = b7_q;
      rev_d = rev_q;
      setup_d = setup_q;
      nost_d = nost_q;
      fres_d = 1'b0;
      rep_d = tel_q;
      base = ref_q;
      // Relay follows zero output continuously, not only per telegram.
      // relay at zero
      relay_d = RELAY_FN & (stop_q != fdcs_pkg::FDCS_RUN) &
                (ACT_FREQ == 16'h0000);
      if (tel_q) begin
         act_d = ACT_FREQ;
         stop_d = c.stop;
         hold_d = c.hold;
         rev_d = c.rev;
         fres_d = c.rst_lvl & ~b7_q;
         b7_d = c.rst_lvl;
         if (c.jog1) begin
            base = $signed(JOG1_SPEED);
         end else if (c.jog2) begin
            base = $signed(JOG2_SPEED);
         end
         if (!c.hold) begin
            if (c.trim_dn) begin
               spd_d = fdcs_pkg::fdcs_sat_add(base,
                          -$signed({1'b0, TRIM_VALUE}));
            end else if (c.trim_up) begin
               spd_d = fdcs_pkg::fdcs_sat_add(base,
                          $signed({1'b0, TRIM_VALUE}));
            end else begin
               spd_d = base;
            end
         end
         if (MULTI_SETUP && c.setup != setup_q &&
             (!IN_OPERATION ||
              (SETUP_LINK[c.setup] && SETUP_LINK[setup_q]))) begin
            setup_d = c.setup;
         end
         if (!raw_q[fdcs_pkg::C_ON1] && raw_q[fdcs_pkg::C_ON2] &&
             raw_q[fdcs_pkg::C_ON3] && raw_q[fdcs_pkg::C_VALID]) begin
            nost_d = 1'b0;
         end
         if (fres_d || !cmd_q[fdcs_pkg::C_ON2] ||
             !cmd_q[fdcs_pkg::C_ON3]) begin
            nost_d = 1'b1;
         end
         stw_d[0] = ok3 & CTRL_READY;
         stw_d[1] = ok3 & CTRL_READY & POWER_OK;
         stw_d[2] = ok3;
         stw_d[3] = TRIP;
         stw_d[4] = cmd_q[fdcs_pkg::C_ON2];
         stw_d[5] = cmd_q[fdcs_pkg::C_ON3];
         stw_d[fdcs_pkg::S_NOSTART] = nost_d;
         stw_d[15:7] = {TIMER_EXC, TORQUE_EXC, VOLT_EXC, AUTO_RESTART,
                        IN_OPERATION, FREQ_OK, BUS_CTRL, AT_REF, WARNING};
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         stw_q   <= 16'h0000;
         act_q   <= 16'h0000;
         rep_q   <= 1'b0;
         spd_q   <= fdcs_pkg::REF_RST;
         stop_q  <= fdcs_pkg::FDCS_COAST;
         hold_q  <= 1'b0;
         fres_q  <= 1'b0;
         b7_q    <= 1'b0;
         rev_q   <= 1'b0;
         setup_q <= fdcs_pkg::SETUP_RST;
         relay_q <= 1'b0;
         nost_q  <= fdcs_pkg::NOSTART_RST;
      end else begin
         stw_q   <= stw_d;
         act_q   <= act_d;
         rep_q   <= rep_d;
         spd_q   <= spd_d;
         stop_q  <= stop_d;
         hold_q  <= hold_d;
         fres_q  <= fres_d;
         b7_q    <= b7_d;
         rev_q   <= rev_d;
         setup_q <= setup_d;
         relay_q <= relay_d;
         nost_q  <= nost_d;
      end
   end

   assign STATE_WORD   = stw_q;
   assign ACTUAL_VALUE = act_q;
   assign REPLY_VALID  = rep_q;
   assign SPEED_CMD    = spd_q;
   assign STOP_MODE    = stop_q;
   assign HOLD_FREQ    = hold_q;
   assign FAULT_RESET  = fres_q;
   assign REVERSE      = rev_q;
   assign ACTIVE_SETUP = setup_q;
   assign RELAY_OUT    = relay_q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   a_reply_two_cycles: assert property (
      TEL_VALID |-> ##2 REPLY_VALID)
      else $error("reply did not follow telegram by two cycles");

   a_invalid_ignored: assert property (
      TEL_VALID && !CMD_WORD[10] |=> $stable(cmd_q))
      else $error("command taken although data invalid");

   a_valid_taken: assert property (
      TEL_VALID && CMD_WORD[10] |=> cmd_q == $past(CMD_WORD))
      else $error("valid command word not taken");

   a_reset_on_edge: assert property (
      FAULT_RESET |-> $past(tel_q) && $past(cmd_q[7]) && !$past(b7_q))
      else $error("fault reset without rising bit 07");

   a_enable_bit: assert property (
      REPLY_VALID |-> STATE_WORD[2] == (&$past(cmd_q[2:0]) && !$past(TRIP)))
      else $error("status enable bit wrong");

   a_mirror_bits: assert property (
      REPLY_VALID |-> STATE_WORD[4] == $past(cmd_q[1]) &&
                      STATE_WORD[5] == $past(cmd_q[2]))
      else $error("status bits 04/05 do not mirror command");

   a_ready_needs_en: assert property (
      REPLY_VALID && !STATE_WORD[2] |-> !STATE_WORD[0] && !STATE_WORD[1])
      else $error("ready reported while stopped or tripped");

   a_drive_ready: assert property (
      REPLY_VALID && STATE_WORD[1] |-> STATE_WORD[0] && $past(POWER_OK))
      else $error("drive ready without power supply");

   a_act_scaling: assert property (
      REPLY_VALID |-> ACTUAL_VALUE == $past(ACT_FREQ))
      else $error("actual value not reported unchanged");

   a_coast_mode: assert property (
      tel_q && !cmd_q[1] |=> STOP_MODE == fdcs_pkg::FDCS_COAST)
      else $error("coast not selected for bit 01 low");

   a_quick_mode: assert property (
      tel_q && &cmd_q[3:0] && !cmd_q[4] && !cmd_q[8] && !cmd_q[9]
      |=> STOP_MODE == fdcs_pkg::FDCS_QUICK)
      else $error("quick stop not selected for bit 04 low");

   a_hold_freeze: assert property (
      tel_q && !cmd_q[5] |=> $stable(SPEED_CMD))
      else $error("speed command moved during hold");

   a_reverse_gate: assert property (
      tel_q && REV_SRC == fdcs_pkg::REV_DIGITAL |=> !REVERSE)
      else $error("reverse taken from digital source setting");
endmodule
`default_nettype wire

// >>> src/fdcs_pkg.sv
// Constants, types and helpers shared by the drive command/status block.
package fdcs_pkg;
   localparam int unsigned WORD_W = 16;
   // One hundred percent of speed reference; values are two's complement.
   localparam logic signed [15:0] REF_FULL = 16'sh4000;
   localparam logic signed [15:0] REF_MAX  = 16'sh7fff;
   localparam logic signed [15:0] REF_MIN  = 16'sh8000;
   // Command word bit positions.
   localparam int unsigned C_ON1   = 0;
   localparam int unsigned C_ON2   = 1;
   localparam int unsigned C_ON3   = 2;
   localparam int unsigned C_NOCST = 3;
   localparam int unsigned C_RAMP  = 4;
   localparam int unsigned C_USERP = 5;
   localparam int unsigned C_START = 6;
   localparam int unsigned C_RESET = 7;
   localparam int unsigned C_JOG1  = 8;
   localparam int unsigned C_JOG2  = 9;
   localparam int unsigned C_VALID = 10;
   localparam int unsigned C_SLOW  = 11;
   localparam int unsigned C_CATCH = 12;
   localparam int unsigned C_SETLO = 13;
   localparam int unsigned C_SETHI = 14;
   localparam int unsigned C_REV   = 15;
   // Status word bit positions that need logic of their own.
   localparam int unsigned S_NOSTART = 6;
   // Reset values.
   localparam logic [15:0] CMD_RST   = 16'h0000;
   localparam logic [15:0] REF_RST   = 16'h0000;
   localparam logic [1:0]  SETUP_RST = 2'h0;
   localparam logic        NOSTART_RST = 1'b1;
   // Reverse source setting that keeps bit 15 without effect.
   localparam logic [1:0]  REV_DIGITAL = 2'h0;

   typedef enum logic [1:0] {
      FDCS_RUN   = 2'h0,
      FDCS_RAMP  = 2'h1,
      FDCS_QUICK = 2'h3,
      FDCS_COAST = 2'h2
   } fdcs_stop_t;

   // Saturating signed add, so trim never wraps a reference around.
   function automatic logic signed [15:0] fdcs_sat_add(
      input logic signed [15:0] a,
      input logic signed [15:0] b);
      logic signed [16:0] s;
      s = 17'(a) + 17'(b);
      if (s[16] != s[15])
         return s[16] ? REF_MIN : REF_MAX;
      return s[15:0];
   endfunction
endpackage

// >>> src/fdcs_cmd_if.sv
// Decoded command fields passed from the decoder to the core.
`timescale 1ns/10ps
`default_nettype none
interface fdcs_cmd_if;
   logic [15:0]          word;
   fdcs_pkg::fdcs_stop_t stop;
   logic                 hold;
   logic                 jog1;
   logic                 jog2;
   logic                 trim_dn;
   logic                 trim_up;
   logic                 rev;
   logic                 rst_lvl;
   logic [1:0]           setup;
   modport dec (input word, output stop, hold, jog1, jog2, trim_dn,
                trim_up, rev, rst_lvl, setup);
   modport usr (output word, input stop, hold, jog1, jog2, trim_dn,
                trim_up, rev, rst_lvl, setup);
endinterface
`default_nettype wire

// >>> src/fdcs_decode.sv
// Combinational decoder of an accepted command word.
`timescale 1ns/10ps
`default_nettype none
module fdcs_decode (
   fdcs_cmd_if.dec        c,
   input wire logic [1:0] rev_src
);
   logic w_jog;

   always_comb begin
      w_jog = ~c.word[fdcs_pkg::C_RAMP] & (&c.word[3:0]);
      c.jog1 = w_jog & c.word[fdcs_pkg::C_JOG1];
      c.jog2 = w_jog & c.word[fdcs_pkg::C_JOG2] & ~c.word[fdcs_pkg::C_JOG1];
      if (!c.word[fdcs_pkg::C_ON2] || !c.word[fdcs_pkg::C_NOCST]) begin
         c.stop = fdcs_pkg::FDCS_COAST;
      // Only a real jog request lifts the bit 04 quick stop.
      end else if (c.jog1 || c.jog2) begin
         c.stop = fdcs_pkg::FDCS_RUN;
      end else if (!c.word[fdcs_pkg::C_ON3] || !c.word[fdcs_pkg::C_RAMP]) begin
         c.stop = fdcs_pkg::FDCS_QUICK;
      end else if (!c.word[fdcs_pkg::C_ON1] || !c.word[fdcs_pkg::C_START]) begin
         c.stop = fdcs_pkg::FDCS_RAMP;
      end else begin
         c.stop = fdcs_pkg::FDCS_RUN;
      end
      c.hold = ~c.word[fdcs_pkg::C_USERP];
      c.trim_dn = c.word[fdcs_pkg::C_SLOW];
      c.trim_up = c.word[fdcs_pkg::C_CATCH] & ~c.word[fdcs_pkg::C_SLOW];
      c.rev = c.word[fdcs_pkg::C_REV] & (rev_src != fdcs_pkg::REV_DIGITAL);
      c.rst_lvl = c.word[fdcs_pkg::C_RESET];
      c.setup = {c.word[fdcs_pkg::C_SETHI], c.word[fdcs_pkg::C_SETLO]};
   end
endmodule
`default_nettype wire

// >>> bench/fdcs_master.sv
// Fieldbus master model that issues cyclic telegrams to the drive block.
`timescale 1ns/10ps
`default_nettype none
module fdcs_master (
   input  wire logic        clk,
   output logic             tel_valid,
   output logic      [15:0] cmd_word,
   output logic      [15:0] speed_ref
);
   initial begin
      tel_valid = 1'b0;
      cmd_word  = 16'h0000;
      speed_ref = 16'h0000;
   end

   // whole telegram words.
   // The reference is a two's complement word with 0x4000 as full scale.
   task automatic send(input logic [15:0] cmd, input logic [15:0] ref_w);
      @(posedge clk);
      tel_valid <= 1'b1;
      cmd_word  <= cmd;
      speed_ref <= ref_w;
      @(posedge clk);
      tel_valid <= 1'b0;
      // Outside a telegram the lines change, so a stale word cannot pass.
      cmd_word  <= ~cmd;
      speed_ref <= ~ref_w;
   endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the drive command and status block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk;
   logic        rstn;
   logic [11:0] flg;
   logic [15:0] act;
   logic [14:0] trim;
   logic [15:0] j1;
   logic [15:0] j2;
   logic [7:0]  cfg;
   logic        tel_v;
   logic [15:0] cmd_w;
   logic [15:0] ref_w;
   logic [15:0] sw_o;
   logic [15:0] av_o;
   logic        rv_o;
   logic [15:0] spd_o;
   logic [1:0]  stp_o;
   logic        hold_o;
   logic        fr_o;
   logic        rev_o;
   logic [1:0]  su_o;
   logic        rly_o;
   logic [15:0] acc;
   logic [15:0] spd;
   logic [1:0]  su;
   logic        nst;
   logic        p7;
   int          err_count;
   int          checks;
   int          cyc;
   localparam logic [15:0] DIR [15] = '{16'h047f, 16'h04ff, 16'h04ff,
      16'h007f, 16'h0476, 16'h0471, 16'h046f, 16'h056f, 16'h066f,
      16'h0c7f, 16'h147f, 16'h1c7f, 16'h647f, 16'hc47f, 16'h041f};

   fdcs_master m (.clk(clk), .tel_valid(tel_v), .cmd_word(cmd_w),
                  .speed_ref(ref_w));

   fdcs_core dut (.CLK(clk), .RSTN(rstn), .TEL_VALID(tel_v),
      .CMD_WORD(cmd_w), .SPEED_REF(ref_w), .ACT_FREQ(act), .TRIP(flg[0]),
      .CTRL_READY(flg[1]), .POWER_OK(flg[2]), .WARNING(flg[3]),
      .AT_REF(flg[4]), .BUS_CTRL(flg[5]), .FREQ_OK(flg[6]),
      .IN_OPERATION(flg[7]), .AUTO_RESTART(flg[8]), .VOLT_EXC(flg[9]),
      .TORQUE_EXC(flg[10]), .TIMER_EXC(flg[11]), .TRIM_VALUE(trim),
      .JOG1_SPEED(j1), .JOG2_SPEED(j2), .MULTI_SETUP(cfg[0]),
      .SETUP_LINK(cfg[4:1]), .REV_SRC(cfg[6:5]), .RELAY_FN(cfg[7]),
      .STATE_WORD(sw_o), .ACTUAL_VALUE(av_o), .REPLY_VALID(rv_o),
      .SPEED_CMD(spd_o), .STOP_MODE(stp_o), .HOLD_FREQ(hold_o),
      .FAULT_RESET(fr_o), .REVERSE(rev_o), .ACTIVE_SETUP(su_o),
      .RELAY_OUT(rly_o));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A second reset in mid-run must bring back the same start state.
   task automatic do_reset;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      acc = 16'h0000;
      spd = 16'h0000;
      su  = 2'h0;
      nst = 1'b1;
      p7  = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check({14'h0000, stp_o}, 16'h0002);
      check(sw_o, 16'h0000);
   endtask

   task automatic tel(input logic [15:0] cmd);
      logic [15:0] c;
      logic [15:0] sw;
      logic [15:0] rf;
      logic [1:0]  st;
      logic        fr;
      logic        jog;
      int          b;
      int          s;
      int          n;
      @(posedge clk);
      flg  <= 12'($urandom);
      act  <= ($urandom & 1) ? 16'h0000 : 16'($urandom);
      trim <= 15'($urandom);
      j1   <= 16'($urandom);
      j2   <= 16'($urandom);
      cfg  <= 8'($urandom);
      case ($urandom % 4)
         0: rf = 16'h4000;
         1: rf = 16'h7fff;
         2: rf = 16'h8000;
         default: rf = 16'($urandom);
      endcase
      m.send(cmd, rf);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (rv_o !== 1'b1 && n < 4);
      if (cmd[10]) acc = cmd;
      c  = acc;
      fr = c[7] & ~p7;
      p7 = c[7];
      if (fr | ~c[1] | ~c[2]) nst = 1'b1;
      else if (cmd[2:0] == 3'h6 && cmd[10]) nst = 1'b0;
      sw = {flg[11:3], nst, c[2], c[1], flg[0], &c[2:0] & ~flg[0],
            &c[2:0] & ~flg[0] & flg[1] & flg[2],
            &c[2:0] & ~flg[0] & flg[1]};
      jog = ~c[4] & (&c[3:0]) & (c[8] | c[9]);
      if (~c[1] | ~c[3]) st = 2'h2;
      else if (jog) st = 2'h0;
      else if (~c[2] | ~c[4]) st = 2'h3;
      else if (~c[0] | ~c[6]) st = 2'h1;
      else st = 2'h0;
      b = jog ? (c[8] ? $signed(j1) : $signed(j2)) : $signed(rf);
      s = c[11] ? b - int'(trim) : (c[12] ? b + int'(trim) : b);
      if (s > 32767) s = 32767;
      if (s < -32768) s = -32768;
      if (c[5]) spd = 16'(s);
      if (cfg[0] & (~flg[7] | (cfg[1 + su] & cfg[1 + c[14:13]])))
         su = c[14:13];
      check({15'h0000, rv_o}, 16'h0001);
      check(sw_o & 16'h0007, sw & 16'h0007);
      check(sw_o & 16'hff88, sw & 16'hff88);
      check(sw_o & 16'h0030, sw & 16'h0030);
      check(sw_o & 16'h0040, sw & 16'h0040);
      check(av_o, act);
      check(spd_o, spd);
      check({14'h0000, stp_o}, {14'h0000, st});
      check({15'h0000, hold_o}, {15'h0000, ~c[5]});
      check({15'h0000, fr_o}, {15'h0000, fr});
      check({15'h0000, rev_o}, {15'h0000, c[15] & |cfg[6:5]});
      check({14'h0000, su_o}, {14'h0000, su});
      @(posedge clk);
      #1;
      check({15'h0000, rv_o | fr_o}, 16'h0000);
      check({15'h0000, rly_o},
            {15'h0000, cfg[7] & (st != 2'h0) & (act == 16'h0000)});
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_count++;
         tally_and_finish;
      end
   end

   initial begin
      err_count = 0;
      checks    = 0;
      cyc       = 0;
      rstn      = 1'b0;
      flg       = 12'h000;
      act       = 16'h0000;
      trim      = 15'h0000;
      j1        = 16'h0000;
      j2        = 16'h0000;
      cfg       = 8'h00;
      void'($urandom(62));
      do_reset;
      foreach (DIR[i]) tel(DIR[i]);
      $display("test directed done");
      for (int i = 0; i < 300; i++) tel(16'($urandom));
      $display("test random done");
      do_reset;
      foreach (DIR[i]) tel(DIR[i]);
      $display("test second reset done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
